// File: inc/spfp_pkg.sv
// Shared constants and types for the supply-pulse fuse programmer
package spfp_pkg;
  // Core clock period, 200 MHz
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Fuse array layout: magnitude, polarity, output/lock field
  localparam int NFUSE = 14;
  localparam int FIDX_W = 4;
  localparam int MAG_W = 8;
  localparam int FALL_W = 2;
  localparam int OUTL_W = 5;
  localparam int POS_MAG = 0;
  localparam int POS_POL = 8;
  localparam int POS_OUTL = 9;
  localparam int OUTL_OPOL = 2;
  localparam int OUTL_LOCK = 4;
  localparam logic [NFUSE-1:0] FUSE_RESET = 14'h0000;
  localparam logic [NFUSE-1:0] FUSE_ONE = 14'h0001;
  localparam logic [FIDX_W-1:0] IDX_MAG = 4'h0;
  localparam logic [FIDX_W-1:0] IDX_POL = 4'h8;
  localparam logic [FIDX_W-1:0] IDX_OUTL = 4'h9;

  // Pointer limits for each physical register in Blow/Read mode
  localparam logic [7:0] PTR_MAG_LIM = 8'h08;
  localparam logic [7:0] PTR_POL_LIM = 8'h01;
  localparam logic [7:0] PTR_OUTL_LIM = 8'h05;

  // Mid-level pulse counts inside keys
  localparam logic [3:0] KEY_HMH_MIDS = 4'h1;
  localparam logic [3:0] KEY_TOUT_MIDS = 4'h3;
  localparam logic [3:0] KEY_DOWN_MIDS = 4'h4;
  localparam logic [3:0] KEY_MODE_MIDS = 4'hB;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_MAX = 4'hF;

  // Try-mode codes
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] CODE_ENTRY = 8'h01;
  localparam logic [7:0] CODE_STEP = 8'h01;
  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam logic [7:0] CODE_TOUT_LIM = 8'h08;
  localparam logic [7:0] CODE_CHK_LO = 8'h08;
  localparam logic [7:0] CODE_CHK_HI = 8'h09;

  typedef enum logic [2:0] {
    S_IDLE, S_H, S_HM, S_HMH, S_PRE, S_TRY, S_BR, S_DONE
  } spfp_state_t;

  typedef enum logic [2:0] {
    SEL_PU, SEL_NU, SEL_PD, SEL_ND, SEL_TOUT, SEL_MAG, SEL_POL, SEL_OUTL
  } spfp_sel_t;
endpackage

// File: inc/spfp_fuse_if.sv
// Carrier between the key decoder and the fuse array
`timescale 1ns/1ps
`default_nettype none
interface spfp_fuse_if import spfp_pkg::*;;
  logic blow_req;
  logic [FIDX_W-1:0] blow_idx;
  logic [NFUSE-1:0] fuse_q;
  modport ctrl (output blow_req, output blow_idx, input fuse_q);
  modport mem (input blow_req, input blow_idx, output fuse_q);
endinterface
`default_nettype wire

// File: design/spfp_fuse_array.sv
// One-time fuse array, set bit by bit, never cleared by a power cycle
`timescale 1ns/1ps
`default_nettype none
module spfp_fuse_array import spfp_pkg::*; (
  input wire logic mclk_in,       // Core clock
  input wire logic fuse_clr_b_in, // Factory unblown state, active low
  input wire logic ce_in,         // Clock enable
  spfp_fuse_if.mem fbus           // Blow request in, fuse state out
);
  logic [NFUSE-1:0] fuse_r;
  wire [NFUSE-1:0] blow_mask = FUSE_ONE << fbus.blow_idx;

  // Supply reset does not reach here: blown fuses survive power cycles
  always_ff @(posedge mclk_in or negedge fuse_clr_b_in) begin
    if (!fuse_clr_b_in) begin
      fuse_r <= FUSE_RESET;
    end else if (ce_in && fbus.blow_req) begin
      fuse_r <= fuse_r | blow_mask;
    end
  end

  assign fbus.fuse_q = fuse_r;

  property p_fuse_sticky;
    @(posedge mclk_in) disable iff (!fuse_clr_b_in)
    ((fuse_r & $past(fuse_r)) == $past(fuse_r));
  endproperty
  a_fuse_sticky: assert property (p_fuse_sticky)
    else $error("blown fuse was cleared");

  property p_single_bit;
    @(posedge mclk_in) disable iff (!fuse_clr_b_in)
    (ce_in && fbus.blow_req) |=> (fuse_r == ($past(fuse_r) | $past(blow_mask)));
  endproperty
  a_single_bit: assert property (p_single_bit)
    else $error("blow set more than the addressed fuse");
endmodule
`default_nettype wire

// File: design/spfp_top.sv
// Supply-pulse key decoder and fuse programmer for the magnetic switch
`timescale 1ns/1ps
`default_nettype none
module spfp_top import spfp_pkg::*; #(
  parameter int unsigned BLOW_TIME_NS = 100000 // Least blow pulse length
) (
  input wire logic mclk_in,                    // Core clock, 200 MHz
  input wire logic rst_b_in,                   // Supply power-on reset, active low
  input wire logic ce_in,                      // Clock enable, freezes all state
  input wire logic fuse_clr_b_in,              // Factory fuse clear, active low
  input wire logic supply_mid_in,              // Supply above mid pulse level
  input wire logic supply_high_in,             // Supply above high pulse level
  input wire logic target_in,                  // Field beyond operate point
  output logic switch_output_pin_out,          // Switch output pin level
  output logic [MAG_W-1:0] operate_point_magnitude_out, // Applied magnitude
  output logic operate_point_polarity_out,     // 1 selects north field
  output logic [FALL_W-1:0] fall_time_out,     // Output fall-time setting
  output logic output_polarity_bit_out,        // Output polarity applied
  output logic check_low_out,                  // Low fuse threshold check on
  output logic check_high_out,                 // High fuse threshold check on
  output logic locked_out,                     // Lock fuse blown
  output logic read_mode_out,                  // Pin shows addressed fuse
  output logic blow_fire_out                   // One-cycle fuse blow strobe
);
  localparam int unsigned BLOW_CYC = (BLOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW = $clog2(BLOW_CYC + 1);
  localparam logic [CW-1:0] HI_SAT = CW'(BLOW_CYC);
  localparam logic [CW-1:0] HI_ZERO = '0;
  localparam logic [CW-1:0] HI_STEP = CW'(1);

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
  endfunction

  // Maps register select and pointer onto the flat fuse index
  function automatic logic [FIDX_W:0] fuse_index(input spfp_sel_t s, input logic [7:0] p);
    logic [FIDX_W-1:0] off;
    off = {1'b0, p[2:0]};
    case (s)
      SEL_MAG: fuse_index = {p < PTR_MAG_LIM, IDX_MAG + off};
      SEL_POL: fuse_index = {p < PTR_POL_LIM, IDX_POL};
      SEL_OUTL: fuse_index = {p < PTR_OUTL_LIM, IDX_OUTL + off};
      default: fuse_index = '0;
    endcase
  endfunction

  spfp_fuse_if fbus ();

  spfp_fuse_array u_fuse (
    .mclk_in(mclk_in),
    .fuse_clr_b_in(fuse_clr_b_in),
    .ce_in(ce_in),
    .fbus(fbus)
  );

  // Pulse classifier: a pulse ends when the supply drops below mid level
  logic in_pulse_r;
  logic saw_high_r;
  logic [CW-1:0] hi_cnt_r;
  logic saw_high_nxt;
  logic [CW-1:0] hi_cnt_nxt;

  wire hi_sat = (hi_cnt_r == HI_SAT);
  wire pulse_end = in_pulse_r & ~supply_mid_in;
  wire tok_m = pulse_end & ~saw_high_r;
  wire tok_h = pulse_end & saw_high_r;
  wire tok_long = hi_sat;

  assign saw_high_nxt = supply_mid_in & (saw_high_r | supply_high_in);
  assign hi_cnt_nxt = !supply_mid_in ? HI_ZERO :
                      (supply_high_in && !hi_sat) ? hi_cnt_r + HI_STEP : hi_cnt_r;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_pulse_r <= 1'b0;
      saw_high_r <= 1'b0;
      hi_cnt_r <= HI_ZERO;
    end else if (ce_in) begin
      in_pulse_r <= supply_mid_in;
      saw_high_r <= saw_high_nxt;
      hi_cnt_r <= hi_cnt_nxt;
    end
  end

  // Fuse fields
  wire [NFUSE-1:0] fq = fbus.fuse_q;
  wire [MAG_W-1:0] fuse_mag = fq[POS_MAG +: MAG_W];
  wire fuse_pol = fq[POS_POL];
  wire [OUTL_W-1:0] fuse_outl = fq[POS_OUTL +: OUTL_W];
  wire lock_w = fuse_outl[OUTL_LOCK];

  // Key decoder state
  spfp_state_t st_r, st_nxt;
  spfp_sel_t sel_r, sel_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] code_r, code_nxt;
  logic blow_r, blow_nxt;
  logic [FIDX_W-1:0] blow_idx_r, blow_idx_nxt;

  wire [FIDX_W:0] fidx = fuse_index(sel_r, code_r);
  wire ptr_ok = fidx[FIDX_W];
  wire [FIDX_W-1:0] ptr_idx = fidx[FIDX_W-1:0];
  wire [7:0] code_inc = code_r + CODE_STEP;

  always_comb begin
    st_nxt = st_r;
    sel_nxt = sel_r;
    cnt_nxt = cnt_r;
    code_nxt = code_r;
    blow_nxt = 1'b0;
    blow_idx_nxt = blow_idx_r;
    case (st_r)
      S_IDLE: begin
        if (tok_h) begin
          st_nxt = S_H;
        end
      end
      S_H: begin
        if (tok_h) begin
          st_nxt = S_TRY;
          sel_nxt = SEL_PU;
          code_nxt = CODE_ENTRY;
          cnt_nxt = CNT_ZERO;
        end else if (tok_m) begin
          st_nxt = S_HM;
          cnt_nxt = CNT_ONE;
        end
      end
      S_HM: begin
        if (tok_m) begin
          cnt_nxt = sat_inc(cnt_r);
        end else if (tok_h && cnt_r == KEY_HMH_MIDS) begin
          st_nxt = S_HMH;
        end else if (tok_h && cnt_r == KEY_TOUT_MIDS) begin
          st_nxt = S_TRY;
          sel_nxt = SEL_TOUT;
          code_nxt = CODE_ENTRY;
          cnt_nxt = CNT_ZERO;
        end else if (tok_h) begin
          st_nxt = S_IDLE;
        end
      end
      S_HMH: begin
        if (tok_h) begin
          st_nxt = S_TRY;
          sel_nxt = SEL_NU;
          code_nxt = CODE_ENTRY;
          cnt_nxt = CNT_ZERO;
        end else if (tok_m) begin
          st_nxt = S_PRE;
          sel_nxt = SEL_POL;
          cnt_nxt = CNT_ONE;
        end
      end
      S_PRE: begin
        if (tok_m) begin
          cnt_nxt = sat_inc(cnt_r);
        end else if (tok_h) begin
          if (cnt_r == KEY_MODE_MIDS && !lock_w) begin
            st_nxt = S_BR;
            code_nxt = CODE_ZERO;
          end else begin
            st_nxt = S_IDLE;
          end
        end
      end
      S_TRY: begin
        if (tok_m) begin
          code_nxt = code_inc;
          cnt_nxt = sat_inc(cnt_r);
        end else if (tok_h) begin
          st_nxt = S_IDLE;
          code_nxt = CODE_ZERO;
          if (cnt_r == KEY_DOWN_MIDS && (sel_r == SEL_PU || sel_r == SEL_NU)) begin
            st_nxt = S_TRY;
            sel_nxt = (sel_r == SEL_PU) ? SEL_PD : SEL_ND;
            code_nxt = CODE_ENTRY;
            cnt_nxt = CNT_ZERO;
          end else if (cnt_r == KEY_MODE_MIDS && !lock_w &&
                       (sel_r == SEL_PU || sel_r == SEL_TOUT)) begin
            st_nxt = S_BR;
            sel_nxt = (sel_r == SEL_PU) ? SEL_MAG : SEL_OUTL;
          end
        end
      end
      S_BR: begin
        if (tok_m) begin
          code_nxt = code_inc;
        end else if (tok_h) begin
          if (tok_long && ptr_ok && !lock_w) begin
            st_nxt = S_DONE;
            blow_nxt = 1'b1;
            blow_idx_nxt = ptr_idx;
          end else begin
            st_nxt = S_IDLE;
          end
        end
      end
      S_DONE: begin
        st_nxt = S_DONE; // Only a supply cycle leaves here
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= S_IDLE;
      sel_r <= SEL_PU;
      cnt_r <= CNT_ZERO;
      code_r <= CODE_ZERO;
      blow_r <= 1'b0;
      blow_idx_r <= IDX_MAG;
    end else if (ce_in) begin
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      blow_r <= blow_nxt;
      blow_idx_r <= blow_idx_nxt;
    end
  end

  assign fbus.blow_req = blow_r;
  assign fbus.blow_idx = blow_idx_r;

  // Try settings overlay unblown fuses; a locked part ignores them
  wire try_on = (st_r == S_TRY) && !lock_w;
  wire sel_down = (sel_r == SEL_PD) || (sel_r == SEL_ND);
  wire sel_bop = try_on && sel_r != SEL_TOUT;
  wire sel_out = try_on && sel_r == SEL_TOUT && code_r < CODE_TOUT_LIM;
  wire [MAG_W-1:0] try_mag = sel_down ? ~code_r : code_r;
  wire [MAG_W-1:0] mag_nxt = fuse_mag | (sel_bop ? try_mag : CODE_ZERO);
  wire pol_nxt = fuse_pol | (sel_bop && (sel_r == SEL_NU || sel_r == SEL_ND));
  wire [FALL_W-1:0] try_fall = sel_out ? code_r[FALL_W-1:0] : '0;
  wire [FALL_W-1:0] fall_nxt = fuse_outl[FALL_W-1:0] | try_fall;
  wire opol_nxt = fuse_outl[OUTL_OPOL] | (sel_out & code_r[OUTL_OPOL]);
  // Threshold checks stay reachable after locking
  wire chk_sel = (st_r == S_TRY) && sel_r == SEL_TOUT;
  wire chk_lo_nxt = chk_sel && code_r == CODE_CHK_LO;
  wire chk_hi_nxt = chk_sel && code_r == CODE_CHK_HI;
  wire rd_nxt = (st_r == S_BR) && !lock_w;
  wire rd_bit = ptr_ok & fq[ptr_idx];
  // Read mode ignores output polarity so that bit can be read too
  wire sw_nxt = rd_nxt ? rd_bit : ~(target_in ^ opol_nxt);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      switch_output_pin_out <= 1'b0;
      operate_point_magnitude_out <= CODE_ZERO;
      operate_point_polarity_out <= 1'b0;
      fall_time_out <= '0;
      output_polarity_bit_out <= 1'b0;
      check_low_out <= 1'b0;
      check_high_out <= 1'b0;
      locked_out <= 1'b0;
      read_mode_out <= 1'b0;
      blow_fire_out <= 1'b0;
    end else if (ce_in) begin
      switch_output_pin_out <= sw_nxt;
      operate_point_magnitude_out <= mag_nxt;
      operate_point_polarity_out <= pol_nxt;
      fall_time_out <= fall_nxt;
      output_polarity_bit_out <= opol_nxt;
      check_low_out <= chk_lo_nxt;
      check_high_out <= chk_hi_nxt;
      locked_out <= lock_w;
      read_mode_out <= rd_nxt;
      blow_fire_out <= blow_nxt;
    end
  end

  property p_entry_code;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_H && tok_h) |=> (st_r == S_TRY && code_r == CODE_ENTRY);
  endproperty
  a_entry_code: assert property (p_entry_code)
    else $error("try code not 1 after key");

  property p_try_wrap;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_TRY && tok_m && code_r == CODE_MAX) |=> (code_r == CODE_ZERO);
  endproperty
  a_try_wrap: assert property (p_try_wrap)
    else $error("try code did not wrap to 0");

  property p_down_invert;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_TRY && sel_r == SEL_PD && !lock_w)
      |=> (operate_point_magnitude_out == ($past(fuse_mag) | ~$past(code_r)));
  endproperty
  a_down_invert: assert property (p_down_invert)
    else $error("down-count code not inverted");

  property p_blow_onehot;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_BR && tok_h && tok_long && !lock_w && ptr_ok)
      |=> (blow_r && blow_idx_r == $past(ptr_idx) && st_r == S_DONE);
  endproperty
  a_blow_onehot: assert property (p_blow_onehot)
    else $error("blow not aimed at pointer bit");

  property p_one_blow;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && blow_r) |=> (!blow_r)[*8];
  endproperty
  a_one_blow: assert property (p_one_blow)
    else $error("second blow in one power cycle");

  property p_lock_block;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && lock_w && st_r == S_TRY && sel_r != SEL_TOUT)
      |=> (operate_point_magnitude_out == $past(fuse_mag) && !read_mode_out);
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("locked part accepted try setting");

  property p_read_out;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_BR && !lock_w)
      |=> (read_mode_out && switch_output_pin_out == $past(rd_bit));
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read mode pin not fuse state");

  property p_bad_key;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_HM && tok_h && cnt_r != KEY_HMH_MIDS && cnt_r != KEY_TOUT_MIDS)
      |=> (st_r == S_IDLE);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("undefined key not dropped");

  property p_check_low;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (ce_in && st_r == S_TRY && sel_r == SEL_TOUT && code_r == CODE_CHK_LO)
      |=> (check_low_out && !check_high_out);
  endproperty
  a_check_low: assert property (p_check_low)
    else $error("code 8 did not enable low check");
endmodule
`default_nettype wire

// File: tb/spfp_prog_model.sv
// Programmer model that drives supply pulse keys
`timescale 1ns/1ps
`default_nettype none
module spfp_prog_model (
  input wire logic mclk_in,     // Core clock
  output logic supply_mid_out,  // Supply above mid level
  output logic supply_high_out  // Supply above high level
);
  initial begin
    supply_mid_out = 1'b0;
    supply_high_out = 1'b0;
  end
  // M is a mid pulse, H a short high pulse, B a blow pulse
  task automatic pulse(input byte c);
    int len;
    len = (c == "B") ? 14 : 2;
    @(posedge mclk_in);
    #1;
    supply_mid_out = 1'b1;
    supply_high_out = (c != "M");
    repeat (len) @(posedge mclk_in);
    #1;
    supply_mid_out = 1'b0;
    supply_high_out = 1'b0;
    // Gap covers the two-edge answer, so the pin can be read on return
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      pulse(s[i]);
    end
  endtask
  task automatic mids(input int n);
    repeat (n) pulse("M");
  endtask
endmodule
`default_nettype wire

// File: tb/test_supply_pulse_fuse_programmer.sv
// Self-checking bench for the supply-pulse fuse programmer
`timescale 1ns/1ps
`default_nettype none
module test_supply_pulse_fuse_programmer;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic fuse_clr_b_in = 1'b0;
  logic target_in = 1'b0;
  logic ce_in = 1'b1;
  wire supply_mid;
  wire supply_high;
  wire pin;
  wire [7:0] mag;
  wire output_polarity_bit;
  wire [1:0] fall;
  wire opol;
  wire chk_lo;
  wire chk_hi;
  wire locked;
  wire rdm;
  wire fire;
  int miscompares = 0;
  int n_tests = 0;
  int n_fire = 0;
  int cycles = 0;

  always #2.5 mclk_in = ~mclk_in;

  spfp_top #(.BLOW_TIME_NS(50)) spfp_top_i (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .fuse_clr_b_in(fuse_clr_b_in), .supply_mid_in(supply_mid),
    .supply_high_in(supply_high), .target_in(target_in),
    .switch_output_pin_out(pin), .operate_point_magnitude_out(mag),
    .operate_point_polarity_out(output_polarity_bit), .fall_time_out(fall),
    .output_polarity_bit_out(opol), .check_low_out(chk_lo),
    .check_high_out(chk_hi), .locked_out(locked), .read_mode_out(rdm),
    .blow_fire_out(fire)
  );

  spfp_prog_model spfp_prog_model_i (
    .mclk_in(mclk_in), .supply_mid_out(supply_mid), .supply_high_out(supply_high)
  );

  always @(posedge mclk_in) begin
    if (fire === 1'b1) begin
      n_fire++;
    end
  end

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Far above the few thousand cycles the sequence needs
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("BAD timeout expected end seen hang");
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic power_cycle();
    @(posedge mclk_in);
    #1;
    rst_b_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask

  task automatic br_key(input string s);
    spfp_prog_model_i.send(s);
    spfp_prog_model_i.mids(11);
    spfp_prog_model_i.send("H");
  endtask

  task automatic t_defaults();
    chk("mag", 8'h00, mag);
    chk("pol", 8'h00, output_polarity_bit);
    chk("fall", 8'h00, fall);
    chk("opol", 8'h00, opol);
    chk("locked", 8'h00, locked);
    target_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("pin", 8'h00, pin);
    target_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("pin", 8'h01, pin);
  endtask

  task automatic t_up();
    spfp_prog_model_i.send("HH");
    chk("mag", 8'h01, mag);
    chk("pol", 8'h00, output_polarity_bit);
    spfp_prog_model_i.mids(2);
    chk("mag", 8'h03, mag);
    spfp_prog_model_i.mids(252);
    chk("mag", 8'hFF, mag);
    spfp_prog_model_i.mids(1);
    chk("mag", 8'h00, mag);
    spfp_prog_model_i.mids(1);
    power_cycle();
    chk("mag", 8'h00, mag);
    spfp_prog_model_i.send("HMHH");
    chk("pol", 8'h01, output_polarity_bit);
    spfp_prog_model_i.mids(1);
    chk("mag", 8'h02, mag);
    power_cycle();
    chk("pol", 8'h00, output_polarity_bit);
  endtask

  task automatic t_down();
    spfp_prog_model_i.send("HHMMMMH");
    chk("mag", 8'hFE, mag);
    chk("pol", 8'h00, output_polarity_bit);
    spfp_prog_model_i.mids(1);
    chk("mag", 8'hFD, mag);
    power_cycle();
    spfp_prog_model_i.send("HMHHMMMMH");
    chk("mag", 8'hFE, mag);
    chk("pol", 8'h01, output_polarity_bit);
    power_cycle();
  endtask

  task automatic t_outreg();
    spfp_prog_model_i.send("HMMMH");
    chk("fall", 8'h01, fall);
    spfp_prog_model_i.mids(2);
    chk("fall", 8'h03, fall);
    chk("opol", 8'h00, opol);
    spfp_prog_model_i.mids(1);
    chk("fall", 8'h00, fall);
    chk("opol", 8'h01, opol);
    target_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("pin", 8'h01, pin);
    target_in = 1'b0;
    spfp_prog_model_i.mids(4);
    chk("chk_lo", 8'h01, chk_lo);
    chk("chk_hi", 8'h00, chk_hi);
    spfp_prog_model_i.mids(1);
    chk("chk_hi", 8'h01, chk_hi);
    chk("chk_lo", 8'h00, chk_lo);
    power_cycle();
    chk("opol", 8'h00, opol);
  endtask

  task automatic t_bad_key();
    // Closing high pulse ends the undefined key, so the decoder is idle again
    spfp_prog_model_i.send("HMMMMMH");
    chk("rdm", 8'h00, rdm);
    chk("fall", 8'h00, fall);
    chk("mag", 8'h00, mag);
    spfp_prog_model_i.send("HH");
    chk("mag", 8'h01, mag);
    power_cycle();
  endtask

  task automatic t_freeze();
    spfp_prog_model_i.send("HH");
    ce_in = 1'b0;
    spfp_prog_model_i.mids(2);
    chk("mag", 8'h01, mag);
    ce_in = 1'b1;
    spfp_prog_model_i.mids(1);
    chk("mag", 8'h02, mag);
    power_cycle();
  endtask

  task automatic t_blow_read();
    int n0;
    n0 = n_fire;
    br_key("HH");
    chk("rdm", 8'h01, rdm);
    chk("pin", 8'h00, pin);
    spfp_prog_model_i.mids(3);
    spfp_prog_model_i.send("B");
    chk("fires", 8'(n0 + 1), 8'(n_fire));
    chk("rdm", 8'h00, rdm);
    power_cycle();
    chk("mag", 8'h08, mag);
    br_key("HH");
    spfp_prog_model_i.send("B");
    power_cycle();
    chk("mag", 8'h09, mag);
    br_key("HH");
    for (int i = 0; i < 8; i++) begin
      chk("pin", (i == 0 || i == 3), pin);
      spfp_prog_model_i.mids(1);
    end
    power_cycle();
    br_key("HMH");
    spfp_prog_model_i.send("B");
    power_cycle();
    chk("pol", 8'h01, output_polarity_bit);
  endtask

  task automatic t_lock();
    int n0;
    br_key("HMMMH");
    spfp_prog_model_i.mids(2);
    spfp_prog_model_i.send("B");
    power_cycle();
    chk("opol", 8'h01, opol);
    br_key("HMMMH");
    spfp_prog_model_i.mids(4);
    spfp_prog_model_i.send("B");
    power_cycle();
    chk("locked", 8'h01, locked);
    n0 = n_fire;
    br_key("HH");
    chk("rdm", 8'h00, rdm);
    spfp_prog_model_i.send("B");
    chk("fires", 8'(n0), 8'(n_fire));
    power_cycle();
    spfp_prog_model_i.send("HH");
    chk("mag", 8'h09, mag);
    power_cycle();
    spfp_prog_model_i.send("HMMMH");
    spfp_prog_model_i.mids(7);
    chk("chk_lo", 8'h01, chk_lo);
  endtask

  initial begin
    repeat (10) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    fuse_clr_b_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    t_defaults();
    t_up();
    t_down();
    t_outreg();
    t_bad_key();
    t_freeze();
    t_blow_read();
    t_lock();
    give_verdict();
  end
endmodule
`default_nettype wire
